// [sim/asq_step_cfg_assertions.sv]
// Purpose: bus timing and decode checks for the step 13/14 bank
// Assumes: sees only the top ports, one clock domain
// Notes:   step 14 decode is left to the bench model to save length
`timescale 1ns/1ps
module asq_step_cfg_assertions (
    input logic        core_clk,
    input logic        rst_n,
    input logic        s_axi_awvalid,
    input logic        s_axi_awready,
    input logic        s_axi_wvalid,
    input logic        s_axi_wready,
    input logic        s_axi_bvalid,
    input logic        s_axi_bready,
    input logic [1:0]  s_axi_bresp,
    input logic        s_axi_arvalid,
    input logic        s_axi_arready,
    input logic        s_axi_rvalid,
    input logic        s_axi_rready,
    input logic [31:0] s_axi_rdata,
    input logic        step13_enable,
    input logic [1:0]  step13_gain_select,
    input logic [2:0]  step13_gain_factor,
    input logic [3:0]  step13_positive_select,
    input logic        step13_negative_select,
    input logic        step13_neg_auto,
    input logic [7:0]  step13_pos_external,
    input logic        step13_pos_temp,
    input logic        step14_pos_supply,
    input logic [3:0]  step14_positive_select
);
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_n);
    // ----------------------------------------------------------------
    // handshake steps
    // ----------------------------------------------------------------
    sequence wr_take;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence ar_take;
        s_axi_arvalid && s_axi_arready;
    endsequence
    sequence r_answer;
        s_axi_rvalid && !s_axi_arready;
    endsequence
    // the register is written one edge after the take, bvalid rises on that same edge
    sequence b_answer;
        !s_axi_awready ##1 s_axi_bvalid;
    endsequence
    a_write_answer: assert property (wr_take |=> b_answer)
        else $error("write response not two cycles after take");
    a_resp_holds: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before taken");
    a_read_answer: assert property (ar_take |=> r_answer)
        else $error("read data not one cycle after take");
    a_rdata_holds: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data changed before taken");
    a_reserved_zero: assert property (s_axi_rvalid |->
        s_axi_rdata[31:16] == 16'h0000 && s_axi_rdata[12:5] == 8'h00)
        else $error("reserved bits read nonzero");
    // ----------------------------------------------------------------
    // decode of step 13
    // ----------------------------------------------------------------
    a_gain_decode: assert property (step13_gain_factor ==
        (step13_gain_select == 2'h0 ? 3'h1 : step13_gain_select == 2'h1 ? 3'h2 : 3'h4))
        else $error("gain factor wrong");
    a_neg_ignored: assert property (step13_positive_select[3] |->
        !step13_negative_select && step13_neg_auto && step13_pos_external == 8'h00)
        else $error("negative select not ignored");
    a_ext_onehot: assert property (!step13_positive_select[3] |->
        step13_pos_external == (8'h01 << step13_positive_select) && !step13_neg_auto)
        else $error("external input select wrong");
    a_temp_code: assert property (step13_pos_temp == (step13_positive_select == 4'h8))
        else $error("temperature select wrong");
    a_reset_words: assert property ($rose(rst_n) |->
        step13_positive_select == 4'hD && !step13_enable &&
        step14_positive_select == 4'hE && step14_pos_supply)
        else $error("reset decode wrong");
endmodule
bind asq_step_cfg asq_step_cfg_assertions u_asq_step_cfg_assertions (.*);

// [sim/asq_step_cfg_tb_top.sv]
// Purpose: self-checking bench for the step 13/14 bank
// Assumes: bench model mdl mirrors both registers
// Notes:   every rd_all pass also compares both decoded output groups
`timescale 1ns/1ps
module asq_step_cfg_tb_top;
    logic        core_clk = 0, rst_n = 0;
    logic [11:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0;
    logic [3:0]  s_axi_wstrb = 0;
    logic        s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic        s_axi_arvalid = 0, s_axi_rready = 0;
    wire         s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire  [1:0]  s_axi_bresp, s_axi_rresp, step13_gain_select, step14_gain_select;
    wire  [31:0] s_axi_rdata;
    wire  [2:0]  step13_gain_factor, step14_gain_factor;
    wire  [3:0]  step13_positive_select, step14_positive_select;
    wire  [7:0]  step13_pos_external, step14_pos_external;
    wire         step13_enable, step13_negative_select, step13_neg_auto, step13_pos_temp;
    wire         step13_pos_short, step13_pos_test_src, step13_pos_supply;
    wire         step14_enable, step14_negative_select, step14_neg_auto, step14_pos_temp;
    wire         step14_pos_short, step14_pos_test_src, step14_pos_supply;
    int          n_mismatch = 0, checked = 0;
    logic [15:0] mdl [2];
    logic [31:0] d;

    wire [23:0] d13 = {step13_enable, step13_gain_select, step13_gain_factor,
        step13_positive_select, step13_negative_select, step13_neg_auto, step13_pos_external,
        step13_pos_temp, step13_pos_short, step13_pos_test_src, step13_pos_supply};
    wire [23:0] d14 = {step14_enable, step14_gain_select, step14_gain_factor,
        step14_positive_select, step14_negative_select, step14_neg_auto, step14_pos_external,
        step14_pos_temp, step14_pos_short, step14_pos_test_src, step14_pos_supply};

    asq_step_cfg u_asq_step_cfg (.*);

    always #50 core_clk = ~core_clk;

    // ----------------------------------------------------------------
    // model and helpers
    // ----------------------------------------------------------------
    function automatic logic [23:0] exp_dec(logic [15:0] v);
        int p;
        int g;
        p = v[3:0];
        g = v[14:13];
        exp_dec = {v[15], v[14:13], g == 0 ? 3'h1 : g == 1 ? 3'h2 : 3'h4, v[3:0],
            v[4] && p < 8, p >= 8, p < 8 ? 8'h01 << p : 8'h00, p == 8, p == 9, p == 10, p >= 11};
    endfunction

    function automatic int idx(logic [11:0] a);
        idx = a == 12'h274 ? 0 : a == 12'h278 ? 1 : 2;
    endfunction

    task automatic chk(string nm, logic [31:0] seen, logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask

    task automatic end_sim;
        $display("checked %0d mismatches %0d", checked, n_mismatch);
        if (n_mismatch == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic wr(logic [11:0] a, logic [31:0] dat, logic [3:0] s);
        int n;
        int i;
        i = idx(a);
        if (i < 2) begin
            for (int b = 0; b < 2; b++) if (s[b]) mdl[i][8*b +: 8] = dat[8*b +: 8];
            mdl[i] = mdl[i] & 16'hE01F;
        end
        @(posedge core_clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= dat;
        s_axi_wstrb <= s;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_awvalid && s_axi_awready === 1'b1) s_axi_awvalid <= 0;
            if (s_axi_wvalid && s_axi_wready === 1'b1) s_axi_wvalid <= 0;
            if (s_axi_bvalid === 1'b1) begin
                chk("bresp", s_axi_bresp, i < 2 ? 2'h0 : 2'h3);
                s_axi_bready <= 0;
                break;
            end
        end
        if (n == 50) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    task automatic rd(logic [11:0] a);
        int n;
        int i;
        i = idx(a);
        @(posedge core_clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (n = 0; n < 50; n++) begin
            @(posedge core_clk);
            if (s_axi_arvalid && s_axi_arready === 1'b1) s_axi_arvalid <= 0;
            if (s_axi_rvalid === 1'b1) begin
                chk("rdata", s_axi_rdata, i < 2 ? {16'h0000, mdl[i]} : 32'h0);
                chk("rresp", s_axi_rresp, i < 2 ? 2'h0 : 2'h3);
                s_axi_rready <= 0;
                break;
            end
        end
        if (n == 50) begin
            n_mismatch++;
            end_sim();
        end
    endtask

    // reads both registers, then compares both decode groups
    task automatic rd_all;
        rd(12'h274);
        rd(12'h278);
        chk("decode13", d13, exp_dec(mdl[0]));
        chk("decode14", d14, exp_dec(mdl[1]));
    endtask

    task automatic do_reset;
        rst_n <= 0;
        repeat (5) @(posedge core_clk);
        rst_n <= 1;
        mdl[0] = 16'h000D;
        mdl[1] = 16'h000E;
    endtask

    // ----------------------------------------------------------------
    // main sequence
    // ----------------------------------------------------------------
    initial begin
        void'($urandom(32'hB58E));
        do_reset();
        rd_all();
        $display("test reset_values done");
        // every positive code on both steps, gain codes cycling, other bits random
        for (int c = 0; c < 32; c++) begin
            d = $urandom;
            d[3:0] = c[4:1];
            d[14:13] = c[2:1];
            wr(c[0] ? 12'h278 : 12'h274, d, 4'hF);
            rd_all();
        end
        $display("test code_sweep done");
        // single byte lanes leave the other lane alone
        wr(12'h274, $urandom, 4'h1);
        wr(12'h278, $urandom, 4'h2);
        wr(12'h274, $urandom, 4'h0);
        rd_all();
        $display("test byte_lanes done");
        // unmapped places answer with an error and change nothing
        wr(12'h27C, $urandom, 4'hF);
        wr(12'h000, $urandom, 4'hF);
        rd(12'h27C);
        rd(12'h270);
        rd_all();
        $display("test unmapped done");
        // a second reset in mid-run restores the reset words
        wr(12'h274, 32'h0000_E011, 4'hF);
        do_reset();
        rd_all();
        $display("test second_reset done");
        end_sim();
    end
endmodule

// [src/asq_defs.vh]
// Purpose: constants for the sequencer step 13/14 configuration bank
// Assumes: AXI4-Lite slave with 32-bit data; word index = byte address / 4
// Notes:   printed offsets are word indexes, byte address is four times them
`ifndef ASQ_DEFS_VH
`define ASQ_DEFS_VH

// ----------------------------------------------------------------------
// register map (word indexes)
// ----------------------------------------------------------------------
`define ASQ_IDX_W          10
`define ASQ_IDX_STEP13     10'h09D
`define ASQ_IDX_STEP14     10'h09E

// ----------------------------------------------------------------------
// reset values and writable bits
// ----------------------------------------------------------------------
`define ASQ_RST_STEP13     16'h000D
`define ASQ_RST_STEP14     16'h000E
`define ASQ_WR_MASK        16'hE01F

// ----------------------------------------------------------------------
// field positions
// ----------------------------------------------------------------------
`define ASQ_EN_BIT         15
`define ASQ_GAIN_HI        14
`define ASQ_GAIN_LO        13
`define ASQ_NEG_BIT        4
`define ASQ_POS_HI         3
`define ASQ_POS_LO         0

// ----------------------------------------------------------------------
// field encodings
// ----------------------------------------------------------------------
`define ASQ_GAIN_X1        2'h0
`define ASQ_GAIN_X2        2'h1
`define ASQ_FACTOR_1       3'h1
`define ASQ_FACTOR_2       3'h2
`define ASQ_FACTOR_4       3'h4
`define ASQ_POS_AUTO_MIN   4'h8
`define ASQ_POS_TEMP       4'h8
`define ASQ_POS_SHORT      4'h9
`define ASQ_POS_TDAC       4'hA
`define ASQ_POS_SUPPLY_MIN 4'hB
`define ASQ_EXT_ONE        8'h01

// ----------------------------------------------------------------------
// bus responses
// ----------------------------------------------------------------------
`define ASQ_RESP_OKAY      2'h0
`define ASQ_RESP_DECERR    2'h3
`define ASQ_BYTE_MASK      8'hFF
`define ASQ_ZERO16         16'h0000

`endif

// [src/asq_step_cfg.v]
// Purpose: configuration registers and decoded routing for sequencer steps 13 and 14
// Assumes: one clock, synchronous active-low reset, AXI4-Lite register access
// Notes:   decoded routing outputs lag a register write by one clock
//
// Notes on behaviour
// - bit 15 enables the step when 1 and excludes it when 0, resetting to 0.
// - bits 14:13 select gain 1 for 00, 2 for 01 and 4 for both 10 and 11, resetting to 00.
// - bit 4 routes analog ground as negative input when 0 and external input seven when 1.
// - bits 3:0 codes 0 to 7 select external inputs zero to seven as positive input.
// - code 8 routes the temperature sensor and code 9 an internal short to ground.
// - code 10 routes test source B and the remaining upper codes select supply monitors.
// - for internal codes that pick the negative input themselves, bit 4 is ignored.
// - step 14 sits at index 9Eh and resets to 000Eh, disabled with positive code 1110.
// - step 13 sits at index 9Dh and resets to 000Dh, disabled with positive code 1101.
//
// The AXI4-Lite slave port was chosen for this implementation.
`timescale 1ns/1ps
`include "asq_defs.vh"

module asq_step_cfg #(
    parameter ADDR_W = 12
) (
    input  wire              core_clk,
    input  wire              rst_n,
    input  wire [ADDR_W-1:0] s_axi_awaddr,
    input  wire              s_axi_awvalid,
    output wire              s_axi_awready,
    input  wire [31:0]       s_axi_wdata,
    input  wire [3:0]        s_axi_wstrb,
    input  wire              s_axi_wvalid,
    output wire              s_axi_wready,
    output wire [1:0]        s_axi_bresp,
    output wire              s_axi_bvalid,
    input  wire              s_axi_bready,
    input  wire [ADDR_W-1:0] s_axi_araddr,
    input  wire              s_axi_arvalid,
    output wire              s_axi_arready,
    output wire [31:0]       s_axi_rdata,
    output wire [1:0]        s_axi_rresp,
    output wire              s_axi_rvalid,
    input  wire              s_axi_rready,
    output wire              step13_enable,
    output wire [1:0]        step13_gain_select,
    output wire [2:0]        step13_gain_factor,
    output wire [3:0]        step13_positive_select,
    output wire              step13_negative_select,
    output wire              step13_neg_auto,
    output wire [7:0]        step13_pos_external,
    output wire              step13_pos_temp,
    output wire              step13_pos_short,
    output wire              step13_pos_test_src,
    output wire              step13_pos_supply,
    output wire              step14_enable,
    output wire [1:0]        step14_gain_select,
    output wire [2:0]        step14_gain_factor,
    output wire [3:0]        step14_positive_select,
    output wire              step14_negative_select,
    output wire              step14_neg_auto,
    output wire [7:0]        step14_pos_external,
    output wire              step14_pos_temp,
    output wire              step14_pos_short,
    output wire              step14_pos_test_src,
    output wire              step14_pos_supply
);

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------
    function [2:0] gain_factor;
        input [1:0] code;
        begin
            if (code == `ASQ_GAIN_X1) begin
                gain_factor = `ASQ_FACTOR_1;
            end else if (code == `ASQ_GAIN_X2) begin
                gain_factor = `ASQ_FACTOR_2;
            end else begin
                gain_factor = `ASQ_FACTOR_4;
            end
        end
    endfunction

    function is_auto;
        input [3:0] code;
        begin
            is_auto = (code >= `ASQ_POS_AUTO_MIN);
        end
    endfunction

    function [7:0] ext_onehot;
        input [3:0] code;
        begin
            if (is_auto(code)) begin
                ext_onehot = 8'h00;
            end else begin
                ext_onehot = `ASQ_EXT_ONE << code[2:0];
            end
        end
    endfunction

    // merges enabled byte lanes into a register, keeping reserved bits zero
    function [15:0] merge_write;
        input [15:0] old;
        input [15:0] data;
        input [1:0]  strb;
        reg   [15:0] lanes;
        begin
            lanes       = {(strb[1] ? `ASQ_BYTE_MASK : 8'h00),
                           (strb[0] ? `ASQ_BYTE_MASK : 8'h00)};
            merge_write = ((old & ~lanes) | (data & lanes)) & `ASQ_WR_MASK;
        end
    endfunction

    // ------------------------------------------------------------------
    // bus state
    // ------------------------------------------------------------------
    reg                   awready_r;
    reg                   wready_r;
    reg                   aw_held_r;
    reg                   w_held_r;
    reg [`ASQ_IDX_W-1:0]  wr_idx_r;
    reg [15:0]            wr_data_r;
    reg [1:0]             wr_strb_r;
    reg                   bvalid_r;
    reg [1:0]             bresp_r;
    reg                   arready_r;
    reg                   rvalid_r;
    reg [31:0]            rdata_r;
    reg [1:0]             rresp_r;
    reg [15:0]            cfg13_r;
    reg [15:0]            cfg14_r;

    wire                  aw_take  = s_axi_awvalid & awready_r;
    wire                  w_take   = s_axi_wvalid & wready_r;
    wire                  wr_fire  = aw_held_r & w_held_r & ~bvalid_r;
    wire                  hit13_w  = (wr_idx_r == `ASQ_IDX_STEP13);
    wire                  hit14_w  = (wr_idx_r == `ASQ_IDX_STEP14);
    wire [`ASQ_IDX_W-1:0] rd_idx   = s_axi_araddr[`ASQ_IDX_W+1:2];
    wire                  hit13_r  = (rd_idx == `ASQ_IDX_STEP13);
    wire                  hit14_r  = (rd_idx == `ASQ_IDX_STEP14);
    wire                  ar_take  = s_axi_arvalid & arready_r;

    // ------------------------------------------------------------------
    // write channel: address and data taken in either order
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_n) begin
            awready_r <= 1'b0;
            wready_r  <= 1'b0;
            aw_held_r <= 1'b0;
            w_held_r  <= 1'b0;
            wr_idx_r  <= {`ASQ_IDX_W{1'b0}};
            wr_data_r <= `ASQ_ZERO16;
            wr_strb_r <= 2'h0;
            bvalid_r  <= 1'b0;
            bresp_r   <= `ASQ_RESP_OKAY;
        end else begin
            if (!aw_held_r && !awready_r && !bvalid_r) begin
                awready_r <= 1'b1;
            end
            if (!w_held_r && !wready_r && !bvalid_r) begin
                wready_r <= 1'b1;
            end
            if (aw_take) begin
                awready_r <= 1'b0;
                aw_held_r <= 1'b1;
                wr_idx_r  <= s_axi_awaddr[`ASQ_IDX_W+1:2];
            end
            if (w_take) begin
                wready_r  <= 1'b0;
                w_held_r  <= 1'b1;
                wr_data_r <= s_axi_wdata[15:0];
                wr_strb_r <= s_axi_wstrb[1:0];
            end
            if (wr_fire) begin
                bvalid_r <= 1'b1;
                bresp_r  <= (hit13_w | hit14_w) ? `ASQ_RESP_OKAY : `ASQ_RESP_DECERR;
            end
            if (bvalid_r && s_axi_bready) begin
                bvalid_r  <= 1'b0;
                aw_held_r <= 1'b0;
                w_held_r  <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // configuration registers
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_n) begin
            cfg13_r <= `ASQ_RST_STEP13;
            cfg14_r <= `ASQ_RST_STEP14;
        end else if (wr_fire) begin
            if (hit13_w) begin
                cfg13_r <= merge_write(cfg13_r, wr_data_r, wr_strb_r);
            end
            if (hit14_w) begin
                cfg14_r <= merge_write(cfg14_r, wr_data_r, wr_strb_r);
            end
        end
    end

    // ------------------------------------------------------------------
    // read channel
    // ------------------------------------------------------------------
    always @(posedge core_clk) begin
        if (!rst_n) begin
            arready_r <= 1'b0;
            rvalid_r  <= 1'b0;
            rdata_r   <= 32'h00000000;
            rresp_r   <= `ASQ_RESP_OKAY;
        end else begin
            if (!arready_r && !rvalid_r) begin
                arready_r <= 1'b1;
            end
            if (ar_take) begin
                arready_r <= 1'b0;
                rvalid_r  <= 1'b1;
                // reserved bits are never stored, so they read as zero
                if (hit13_r) begin
                    rdata_r <= {16'h0000, cfg13_r};
                    rresp_r <= `ASQ_RESP_OKAY;
                end else if (hit14_r) begin
                    rdata_r <= {16'h0000, cfg14_r};
                    rresp_r <= `ASQ_RESP_OKAY;
                end else begin
                    rdata_r <= 32'h00000000;
                    rresp_r <= `ASQ_RESP_DECERR;
                end
            end
            if (rvalid_r && s_axi_rready) begin
                rvalid_r <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------------
    // decoded routing, registered so every output is a flop
    // ------------------------------------------------------------------
    // during reset the decoders see the reset words so outputs agree with them
    wire [15:0] src13 = rst_n ? cfg13_r : `ASQ_RST_STEP13;
    wire [15:0] src14 = rst_n ? cfg14_r : `ASQ_RST_STEP14;
    wire [3:0]  pos13 = src13[`ASQ_POS_HI:`ASQ_POS_LO];
    wire [3:0]  pos14 = src14[`ASQ_POS_HI:`ASQ_POS_LO];
    wire [1:0]  gn13  = src13[`ASQ_GAIN_HI:`ASQ_GAIN_LO];
    wire [1:0]  gn14  = src14[`ASQ_GAIN_HI:`ASQ_GAIN_LO];

    reg         s13_en_r;
    reg [1:0]   s13_gain_r;
    reg [2:0]   s13_fac_r;
    reg [3:0]   s13_pos_r;
    reg         s13_neg_r;
    reg         s13_auto_r;
    reg [7:0]   s13_ext_r;
    reg         s13_temp_r;
    reg         s13_short_r;
    reg         s13_tdac_r;
    reg         s13_sup_r;
    reg         s14_en_r;
    reg [1:0]   s14_gain_r;
    reg [2:0]   s14_fac_r;
    reg [3:0]   s14_pos_r;
    reg         s14_neg_r;
    reg         s14_auto_r;
    reg [7:0]   s14_ext_r;
    reg         s14_temp_r;
    reg         s14_short_r;
    reg         s14_tdac_r;
    reg         s14_sup_r;

    always @(posedge core_clk) begin
        s13_en_r    <= src13[`ASQ_EN_BIT];
        s13_gain_r  <= gn13;
        s13_fac_r   <= gain_factor(gn13);
        s13_pos_r   <= pos13;
        s13_auto_r  <= is_auto(pos13);
        // negative select counts only for external positive codes
        s13_neg_r   <= src13[`ASQ_NEG_BIT] & ~is_auto(pos13);
        s13_ext_r   <= ext_onehot(pos13);
        s13_temp_r  <= (pos13 == `ASQ_POS_TEMP);
        s13_short_r <= (pos13 == `ASQ_POS_SHORT);
        s13_tdac_r  <= (pos13 == `ASQ_POS_TDAC);
        s13_sup_r   <= (pos13 >= `ASQ_POS_SUPPLY_MIN);
        s14_en_r    <= src14[`ASQ_EN_BIT];
        s14_gain_r  <= gn14;
        s14_fac_r   <= gain_factor(gn14);
        s14_pos_r   <= pos14;
        s14_auto_r  <= is_auto(pos14);
        s14_neg_r   <= src14[`ASQ_NEG_BIT] & ~is_auto(pos14);
        s14_ext_r   <= ext_onehot(pos14);
        s14_temp_r  <= (pos14 == `ASQ_POS_TEMP);
        s14_short_r <= (pos14 == `ASQ_POS_SHORT);
        s14_tdac_r  <= (pos14 == `ASQ_POS_TDAC);
        s14_sup_r   <= (pos14 >= `ASQ_POS_SUPPLY_MIN);
    end

    // ------------------------------------------------------------------
    // output wiring
    // ------------------------------------------------------------------
    assign s_axi_awready          = awready_r;
    assign s_axi_wready           = wready_r;
    assign s_axi_bresp            = bresp_r;
    assign s_axi_bvalid           = bvalid_r;
    assign s_axi_arready          = arready_r;
    assign s_axi_rdata            = rdata_r;
    assign s_axi_rresp            = rresp_r;
    assign s_axi_rvalid           = rvalid_r;
    assign step13_enable          = s13_en_r;
    assign step13_gain_select     = s13_gain_r;
    assign step13_gain_factor     = s13_fac_r;
    assign step13_positive_select = s13_pos_r;
    assign step13_negative_select = s13_neg_r;
    assign step13_neg_auto        = s13_auto_r;
    assign step13_pos_external    = s13_ext_r;
    assign step13_pos_temp        = s13_temp_r;
    assign step13_pos_short       = s13_short_r;
    assign step13_pos_test_src    = s13_tdac_r;
    assign step13_pos_supply      = s13_sup_r;
    assign step14_enable          = s14_en_r;
    assign step14_gain_select     = s14_gain_r;
    assign step14_gain_factor     = s14_fac_r;
    assign step14_positive_select = s14_pos_r;
    assign step14_negative_select = s14_neg_r;
    assign step14_neg_auto        = s14_auto_r;
    assign step14_pos_external    = s14_ext_r;
    assign step14_pos_temp        = s14_temp_r;
    assign step14_pos_short       = s14_short_r;
    assign step14_pos_test_src    = s14_tdac_r;
    assign step14_pos_supply      = s14_sup_r;

endmodule
